// ==== verilog/disc_tag_bus_command_unit.sv ====
// Drive-side tag bus command decoder and control bus exchange
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module disc_tag_bus_command_unit #(
  parameter int SEEK_CYCLES = disc_tag_pkg::SEEK_CYCLES,
  parameter logic [5:0] SECTORS_PER_TRACK = 6'h30
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] tagBus,
  input wire logic tagStrobe,
  input wire logic [10:0] controlBusIn_n,
  output logic [10:0] controlBusOut_n,
  output logic [10:0] controlBusOe,
  output logic select_lamp_n,
  output logic selected,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  typedef enum logic [1:0] {IDLE, SEEKING, SETTLED} seek_e;

  seek_e seekState;
  logic [10:0] rx;
  logic [3:0] cmd;
  logic strobeSeen;
  logic act;
  logic actSel;
  logic [9:0] targetCyl;
  logic [9:0] currentCyl;
  logic [5:0] sectorAddr;
  logic [2:0] headAddr;
  logic [5:0] liveSector;
  logic [5:0] offsetMag;
  logic offsetSign;
  logic seekCheck;
  logic firstStatus;
  logic attention;
  logic [15:0] seekTimer;
  logic [31:0] ctrl;
  logic [3:0] irqStatus;
  logic [3:0] irqEnable;
  logic [3:0] irqEvents;
  logic runPrev;
  logic headsPrev;
  logic [10:0] statusWord;
  logic [2:0] unitSwitch;
  logic apbWrite;
  logic apbRead;
  logic clrAttn;
  logic clrFirst;
  logic reposition;

  function automatic logic isCmd(input logic [3:0] c, input logic [3:0] code);
    return c == code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Receive and decode

  assign rx = ~controlBusIn_n;
  assign cmd = tagBus;
  assign unitSwitch = ctrl[disc_tag_pkg::CTRL_UNIT_LSB +: disc_tag_pkg::UNIT_W];
  // One action per strobe assertion, unused codes dropped
  assign act = tagStrobe && !strobeSeen && !isCmd(cmd, disc_tag_pkg::CMD_UNUSED_A)
    && !isCmd(cmd, disc_tag_pkg::CMD_UNUSED_B);
  assign actSel = act && selected;
  assign clrAttn = actSel && isCmd(cmd, disc_tag_pkg::CMD_STATUS_CLEAR) && rx[disc_tag_pkg::CLR_ATTN_BIT];
  assign clrFirst = actSel && isCmd(cmd, disc_tag_pkg::CMD_STATUS_CLEAR) && rx[disc_tag_pkg::CLR_FIRST_BIT];
  assign reposition = actSel && isCmd(cmd, disc_tag_pkg::CMD_SET_OFFSET);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      strobeSeen <= 1'b0;
    else
      strobeSeen <= tagStrobe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      selected <= 1'b0;
      select_lamp_n <= 1'b1;
      runPrev <= 1'b0;
    end
    else
    begin
      runPrev <= ctrl[disc_tag_pkg::CTRL_RUN_SWITCH];
      if ((ctrl[disc_tag_pkg::CTRL_RUN_SWITCH] && !runPrev) ||
          (act && (isCmd(cmd, disc_tag_pkg::CMD_CONTROLLER_PRESET) ||
                   isCmd(cmd, disc_tag_pkg::CMD_DISCONNECT))))
      begin
        selected <= 1'b0;
        select_lamp_n <= 1'b1;
      end
      else if (act && isCmd(cmd, disc_tag_pkg::CMD_UNIT_SELECT))
      begin
        selected <= rx[disc_tag_pkg::UNIT_LSB +: disc_tag_pkg::UNIT_W] == unitSwitch;
        select_lamp_n <= rx[disc_tag_pkg::UNIT_LSB +: disc_tag_pkg::UNIT_W] != unitSwitch;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address registers and checks

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sectorAddr <= 6'h00;
      headAddr <= 3'h0;
      seekCheck <= 1'b0;
    end
    else if (act && isCmd(cmd, disc_tag_pkg::CMD_CONTROLLER_PRESET))
    begin
      sectorAddr <= 6'h00;
      headAddr <= 3'h0;
      seekCheck <= 1'b0;
    end
    else if (actSel && isCmd(cmd, disc_tag_pkg::CMD_SECTOR_ONLY_LOAD))
    begin
      // Head field deliberately not looked at
      if (rx[disc_tag_pkg::SEC_LSB +: disc_tag_pkg::SEC_W] <= disc_tag_pkg::MAX_SECTOR)
      begin
        sectorAddr <= rx[disc_tag_pkg::SEC_LSB +: disc_tag_pkg::SEC_W];
        seekCheck <= 1'b0;
      end
      else
        seekCheck <= 1'b1;
    end
    else if (actSel && isCmd(cmd, disc_tag_pkg::CMD_ADDRESS_RECORD))
    begin
      if (rx[disc_tag_pkg::SEC_LSB +: disc_tag_pkg::SEC_W] <= disc_tag_pkg::MAX_SECTOR)
        sectorAddr <= rx[disc_tag_pkg::SEC_LSB +: disc_tag_pkg::SEC_W];
      if (rx[disc_tag_pkg::HEAD_LSB +: disc_tag_pkg::HEAD_W] <= disc_tag_pkg::MAX_HEAD)
        headAddr <= rx[disc_tag_pkg::HEAD_LSB +: disc_tag_pkg::HEAD_W];
      seekCheck <= (rx[disc_tag_pkg::SEC_LSB +: disc_tag_pkg::SEC_W] > disc_tag_pkg::MAX_SECTOR) ||
        (rx[disc_tag_pkg::HEAD_LSB +: disc_tag_pkg::HEAD_W] > disc_tag_pkg::MAX_HEAD);
    end
    else if (actSel && isCmd(cmd, disc_tag_pkg::CMD_SEEK))
      seekCheck <= rx[disc_tag_pkg::CYL_LSB +: disc_tag_pkg::CYL_W] > disc_tag_pkg::MAX_CYL ||
        seekState == SEEKING;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      offsetMag <= 6'h00;
      offsetSign <= 1'b0;
    end
    else if (reposition)
    begin
      offsetMag <= rx[disc_tag_pkg::OFS_LSB +: disc_tag_pkg::OFS_W];
      offsetSign <= rx[disc_tag_pkg::OFS_SIGN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Seek and recalibrate positioner model

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      seekState <= IDLE;
      targetCyl <= disc_tag_pkg::HOME_CYL;
      currentCyl <= disc_tag_pkg::HOME_CYL;
      seekTimer <= 16'h0000;
    end
    else if (actSel && isCmd(cmd, disc_tag_pkg::CMD_RECALIBRATE))
    begin
      targetCyl <= disc_tag_pkg::HOME_CYL;
      currentCyl <= disc_tag_pkg::HOME_CYL;
      seekState <= SEEKING;
      seekTimer <= 16'(SEEK_CYCLES);
    end
    else if (actSel && isCmd(cmd, disc_tag_pkg::CMD_SEEK) && seekState != SEEKING &&
             rx[disc_tag_pkg::CYL_LSB +: disc_tag_pkg::CYL_W] <= disc_tag_pkg::MAX_CYL)
    begin
      targetCyl <= rx[disc_tag_pkg::CYL_LSB +: disc_tag_pkg::CYL_W];
      seekState <= SEEKING;
      seekTimer <= 16'(SEEK_CYCLES);
    end
    else if (reposition)
    begin
      seekState <= SEEKING;
      seekTimer <= 16'(SEEK_CYCLES);
    end
    else
    begin
      unique case (seekState)
        IDLE: seekState <= IDLE;
        SEEKING:
        begin
          if (seekTimer == 16'h0000)
          begin
            currentCyl <= targetCyl;
            seekState <= SETTLED;
          end
          else
            seekTimer <= seekTimer - 16'h0001;
        end
        SETTLED: seekState <= IDLE;
        default: seekState <= IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      attention <= 1'b0;
      firstStatus <= 1'b0;
      headsPrev <= 1'b0;
    end
    else
    begin
      headsPrev <= ctrl[disc_tag_pkg::CTRL_HEADS_LOADED];
      // Sets win over clears
      if (seekState == SETTLED ||
          (actSel && isCmd(cmd, disc_tag_pkg::CMD_SEEK) &&
           rx[disc_tag_pkg::CYL_LSB +: disc_tag_pkg::CYL_W] > disc_tag_pkg::MAX_CYL))
        attention <= 1'b1;
      else if (clrAttn || (act && isCmd(cmd, disc_tag_pkg::CMD_CONTROLLER_PRESET)))
        attention <= 1'b0;
      if (ctrl[disc_tag_pkg::CTRL_HEADS_LOADED] && !headsPrev)
        firstStatus <= 1'b1;
      else if (clrFirst || (act && isCmd(cmd, disc_tag_pkg::CMD_CONTROLLER_PRESET)))
        firstStatus <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      liveSector <= 6'h00;
    else if (liveSector == SECTORS_PER_TRACK - 6'h01)
      liveSector <= 6'h00;
    else
      liveSector <= liveSector + 6'h01;
  end

  always_comb
  begin
    statusWord = '0;
    statusWord[disc_tag_pkg::ST_BUSY] = seekState != IDLE;
    statusWord[disc_tag_pkg::ST_READY] = ctrl[disc_tag_pkg::CTRL_HEADS_LOADED];
    statusWord[disc_tag_pkg::ST_SEEK_CHECK] = seekCheck;
    statusWord[disc_tag_pkg::ST_FIRST] = firstStatus;
    statusWord[disc_tag_pkg::ST_FAULT] = ctrl[disc_tag_pkg::CTRL_FAULT];
    statusWord[disc_tag_pkg::ST_FORMAT] = ctrl[disc_tag_pkg::CTRL_FORMAT];
    statusWord[disc_tag_pkg::ST_READ_ONLY] = ctrl[disc_tag_pkg::CTRL_READ_ONLY];
    statusWord[disc_tag_pkg::ST_ATTN] = attention;
    statusWord[disc_tag_pkg::ST_SECTOR_CMP] = liveSector == sectorAddr &&
      (isCmd(cmd, disc_tag_pkg::CMD_READ) || isCmd(cmd, disc_tag_pkg::CMD_WRITE)) && tagStrobe;
    statusWord[disc_tag_pkg::ST_TYPE_HI:disc_tag_pkg::ST_TYPE_LO] = disc_tag_pkg::DRIVE_TYPE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bus drivers

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      controlBusOut_n <= '1;
      controlBusOe <= '0;
    end
    else if (tagStrobe && selected && (isCmd(cmd, disc_tag_pkg::CMD_READ) ||
             isCmd(cmd, disc_tag_pkg::CMD_WRITE) || isCmd(cmd, disc_tag_pkg::CMD_STATUS_REQUEST)))
    begin
      controlBusOut_n <= ~statusWord;
      controlBusOe <= '1;
    end
    else if (tagStrobe && selected && isCmd(cmd, disc_tag_pkg::CMD_SECTOR_REPORT))
    begin
      controlBusOut_n <= ~{headAddr, 2'h0, liveSector};
      controlBusOe <= '1;
    end
    else if (tagStrobe && attention && isCmd(cmd, disc_tag_pkg::CMD_IDENTITY_POLL))
    begin
      // Only the own unit line is pulled low
      controlBusOut_n <= ~(11'h001 << unitSwitch);
      controlBusOe <= 11'h001 << unitSwitch;
    end
    else
    begin
      controlBusOut_n <= '1;
      controlBusOe <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign irqEvents = {actSel && isCmd(cmd, disc_tag_pkg::CMD_UNIT_SELECT), seekState == SETTLED,
                      seekCheck, act};
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !penable && !pwrite;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      irqStatus <= '0;
    else if (apbWrite && paddr == disc_tag_pkg::REG_IRQ_CLEAR)
      irqStatus <= irqEvents | (irqStatus & ~pwdata[disc_tag_pkg::IRQ_W-1:0]);
    else
      irqStatus <= irqStatus | irqEvents;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irqStatus & irqEnable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl <= '0;
      irqEnable <= '0;
    end
    else if (apbWrite && paddr == disc_tag_pkg::REG_CTRL)
      ctrl <= pwdata;
    else if (apbWrite && paddr == disc_tag_pkg::REG_IRQ_ENABLE)
      irqEnable <= pwdata[disc_tag_pkg::IRQ_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        pslverr <= !(paddr inside {disc_tag_pkg::REG_CTRL, disc_tag_pkg::REG_STATUS,
          disc_tag_pkg::REG_ADDR, disc_tag_pkg::REG_OFFSET, disc_tag_pkg::REG_IRQ_STATUS,
          disc_tag_pkg::REG_IRQ_ENABLE, disc_tag_pkg::REG_IRQ_CLEAR});
        prdata <= '0;
      end
      if (apbRead)
      begin
        unique case (paddr)
          disc_tag_pkg::REG_CTRL: prdata <= ctrl;
          disc_tag_pkg::REG_STATUS: prdata <= {20'h00000, selected, statusWord};
          disc_tag_pkg::REG_ADDR: prdata <= {headAddr, sectorAddr, currentCyl, 3'h0, targetCyl};
          disc_tag_pkg::REG_OFFSET: prdata <= {25'h0, offsetSign, offsetMag};
          disc_tag_pkg::REG_IRQ_STATUS: prdata <= {28'h0000000, irqStatus};
          disc_tag_pkg::REG_IRQ_ENABLE: prdata <= {28'h0000000, irqEnable};
          default: prdata <= '0;
        endcase
      end
    end
  end

endmodule // disc_tag_bus_command_unit

// ==== verilog/disc_tag_pkg.sv ====
// Constants for the drive-side tag bus command unit
package disc_tag_pkg;
  localparam int CBUS_W = 11;
  localparam int TAG_W = 4;
  // Tag bus command codes
  localparam logic [3:0] CMD_NOP0 = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] CMD_STATUS_REQUEST = 4'h3;
  localparam logic [3:0] CMD_IDENTITY_POLL = 4'h4;
  localparam logic [3:0] CMD_CONTROLLER_PRESET = 4'h5;
  localparam logic [3:0] CMD_SECTOR_REPORT = 4'h6;
  localparam logic [3:0] CMD_UNUSED_A = 4'h7;
  localparam logic [3:0] CMD_SEEK = 4'h8;
  localparam logic [3:0] CMD_ADDRESS_RECORD = 4'h9;
  localparam logic [3:0] CMD_UNIT_SELECT = 4'ha;
  localparam logic [3:0] CMD_RECALIBRATE = 4'hb;
  localparam logic [3:0] CMD_SECTOR_ONLY_LOAD = 4'hc;
  localparam logic [3:0] CMD_SET_OFFSET = 4'hd;
  localparam logic [3:0] CMD_STATUS_CLEAR = 4'he;
  localparam logic [3:0] CMD_UNUSED_B = 4'hf;
  localparam logic [3:0] CMD_DISCONNECT = 4'h0;
  // Control bus field layout
  localparam int CYL_LSB = 0;
  localparam int CYL_W = 10;
  localparam int SEC_LSB = 0;
  localparam int SEC_W = 6;
  localparam int HEAD_LSB = 8;
  localparam int HEAD_W = 3;
  localparam int UNIT_LSB = 0;
  localparam int UNIT_W = 3;
  localparam int OFS_LSB = 0;
  localparam int OFS_W = 6;
  localparam int OFS_SIGN_BIT = 7;
  localparam int CLR_ATTN_BIT = 0;
  localparam int CLR_FIRST_BIT = 1;
  // Status word bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_SEEK_CHECK = 2;
  localparam int ST_FIRST = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_FORMAT = 5;
  localparam int ST_READ_ONLY = 6;
  localparam int ST_ATTN = 7;
  localparam int ST_SECTOR_CMP = 8;
  localparam int ST_TYPE_LO = 9;
  localparam int ST_TYPE_HI = 10;
  // Legal limits
  localparam logic [9:0] MAX_CYL = 10'h336;
  localparam logic [5:0] MAX_SECTOR = 6'h2f;
  localparam logic [2:0] MAX_HEAD = 3'h4;
  localparam logic [6:0] MAX_OFFSET = 7'h53;
  localparam logic [9:0] HOME_CYL = 10'h000;
  localparam logic [1:0] DRIVE_TYPE = 2'h1;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int EV_CMD = 0;
  localparam int EV_SEEK_CHECK = 1;
  localparam int EV_ATTN = 2;
  localparam int EV_SELECT = 3;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0c;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h18;
  // Control register bits
  localparam int CTRL_RUN_SWITCH = 0;
  localparam int CTRL_FORMAT = 1;
  localparam int CTRL_READ_ONLY = 2;
  localparam int CTRL_FAULT = 3;
  localparam int CTRL_HEADS_LOADED = 4;
  localparam int CTRL_UNIT_LSB = 8;
  localparam int CTRL_SEEK_DONE = 12;
  // Internal cycle times
  localparam int SEEK_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEEK_CYCLES = SEEK_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== verification/disc_tag_bus_command_unit_properties.sv ====
// Port-level checks of the tag bus command unit
`timescale 1ns/1ps
module disc_tag_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] tagBus,
  input wire logic tagStrobe,
  input wire logic [10:0] controlBusOut_n,
  input wire logic [10:0] controlBusOe,
  input wire logic select_lamp_n,
  input wire logic selected
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic statusCmd;
  assign statusCmd = tagStrobe && selected && tagBus inside {4'h1, 4'h2, 4'h3};
  ////////////////////////////////////////////////////////////////////////////
  a_release_after_strobe: assert property (!tagStrobe |=> controlBusOe == 11'h000)
    else $error("bus driven after strobe");
  a_status_drive_all: assert property (statusCmd |=> controlBusOe == 11'h7ff)
    else $error("status word not driven");
  a_type_active_low: assert property (statusCmd |=> controlBusOut_n[10:9] == 2'b10)
    else $error("drive type wrong on wire");
  a_unselected_quiet: assert property (tagStrobe && !selected && tagBus != 4'h4 |=> controlBusOe == 11'h000)
    else $error("unselected drive drove bus");
  a_ident_one_line: assert property (tagStrobe && tagBus == 4'h4
    |=> $onehot0(controlBusOe) && (controlBusOut_n & controlBusOe) == 11'h000)
    else $error("identity not one low line");
  a_unused_quiet: assert property (tagStrobe && tagBus inside {4'h7, 4'hf} |=> controlBusOe == 11'h000)
    else $error("unused code drove bus");
  a_lamp_tracks: assert property (select_lamp_n == !selected)
    else $error("lamp disagrees with select");
  a_select_cause: assert property ($rose(selected) |-> $past(tagStrobe) && $past(tagBus) == 4'ha)
    else $error("select without unit select");
  a_deselect_cmd: assert property (tagStrobe && !$past(tagStrobe) && tagBus inside {4'h0, 4'h5} |=> !selected)
    else $error("still selected after deselect");
  a_report_sector: assert property (tagStrobe && selected && tagBus == 4'h6
    |=> controlBusOe[0] && ~controlBusOut_n[5:0] <= 6'h2f)
    else $error("sector report out of range");
  c_select: cover property ($rose(selected));
  c_status: cover property (statusCmd);
  c_ident: cover property (tagStrobe && tagBus == 4'h4 ##1 controlBusOe != 11'h000);
endmodule // disc_tag_checker

bind disc_tag_bus_command_unit disc_tag_checker checker_u (
  .clk(clk), .rstn(rstn), .tagBus(tagBus), .tagStrobe(tagStrobe),
  .controlBusOut_n(controlBusOut_n), .controlBusOe(controlBusOe),
  .select_lamp_n(select_lamp_n), .selected(selected)
);

// ==== verification/disc_tag_controller_model.sv ====
// Behavioural disc controller on the tag and control buses
`timescale 1ns/1ps
module disc_tag_controller_model (
  input wire logic clk,
  input wire logic [10:0] wireLevel,
  output logic [3:0] tagBus,
  output logic tagStrobe,
  output logic [10:0] ctlDrive_n
);
  logic [10:0] lastBus;
  int holdCycles = 3;
  initial
  begin
    tagBus = 4'h0;
    tagStrobe = 1'b0;
    ctlDrive_n = 11'h7ff;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One command; bus seen at strobe end kept positive-true
  task automatic issue(input logic [3:0] code, input logic [10:0] data);
    @(posedge clk);
    tagBus <= code;
    tagStrobe <= 1'b1;
    // Released lines float high on the terminators
    ctlDrive_n <= code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6} ? 11'h7ff : ~data;
    repeat (holdCycles) @(posedge clk);
    lastBus = ~wireLevel;
    tagStrobe <= 1'b0;
    @(posedge clk);
    ctlDrive_n <= 11'h7ff;
    repeat (2) @(posedge clk);
  endtask
endmodule // disc_tag_controller_model

// ==== verification/disc_tag_bus_command_unit_tb.sv ====
// Self-checking bench for the tag bus command unit
`timescale 1ns/1ps
module disc_tag_bus_command_unit_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdData;
  logic pready, pslverr, errSeen, irq, tagStrobe, lamp_n, selected;
  logic [3:0] tagBus;
  logic [10:0] ctlDrive_n, wireLevel, devOut_n, devOe;
  int num_errors = 0;
  int comparisons = 0;

  always #5 clk = ~clk;
  // Open-collector lines, pulled up
  assign wireLevel = ctlDrive_n & (devOut_n | ~devOe);

  disc_tag_bus_command_unit #(.SEEK_CYCLES(4)) dut_u (
    .clk(clk), .rstn(rstn), .tagBus(tagBus), .tagStrobe(tagStrobe), .controlBusIn_n(wireLevel),
    .controlBusOut_n(devOut_n), .controlBusOe(devOe), .select_lamp_n(lamp_n), .selected(selected),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
  );
  disc_tag_controller_model ctl_u (
    .clk(clk), .wireLevel(wireLevel), .tagBus(tagBus), .tagStrobe(tagStrobe), .ctlDrive_n(ctlDrive_n)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge clk);
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rdData & mask, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end
    while (rdData[0] !== 1'b0 && n < 20);
    if (n == 20)
      num_errors++;
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // Run on, heads loaded, unit switch 3
    apb(1'b1, 8'h00, 32'h311);
    ctl_u.issue(4'h3, 11'h000);
    check(ctl_u.lastBus, 11'h000);
    ctl_u.issue(4'ha, 11'h002);
    check(selected, 1'b0);
    ctl_u.issue(4'ha, 11'h003);
    check({lamp_n, selected}, 2'b01);
    $display("test select done");
    ctl_u.issue(4'h3, 11'h000);
    check(ctl_u.lastBus & 11'h67e, 11'h20a);
    rd_chk(8'h04, 32'he7e, 32'ha0a);
    ctl_u.issue(4'h1, 11'h000);
    check(ctl_u.lastBus & 11'h67e, 11'h20a);
    ctl_u.issue(4'h2, 11'h000);
    check(ctl_u.lastBus & 11'h67e, 11'h20a);
    ctl_u.issue(4'he, 11'h002);
    rd_chk(8'h04, 32'h8, 32'h0);
    $display("test status done");
    ctl_u.issue(4'h9, 11'h405);
    rd_chk(8'h08, 32'hff80_0000, {3'd4, 6'd5, 23'd0});
    ctl_u.issue(4'hc, 11'h22f);
    rd_chk(8'h08, 32'hff80_0000, {3'd4, 6'd47, 23'd0});
    ctl_u.issue(4'hc, 11'h030);
    rd_chk(8'h08, 32'hff80_0000, {3'd4, 6'd47, 23'd0});
    rd_chk(8'h04, 32'h4, 32'h4);
    ctl_u.holdCycles = 6;
    ctl_u.issue(4'h6, 11'h000);
    check(ctl_u.lastBus[10:8], 3'd4);
    check(ctl_u.lastBus[5:0] <= 6'd47, 1'b1);
    ctl_u.holdCycles = 3;
    $display("test address done");
    ctl_u.issue(4'h8, 11'd822);
    wait_idle();
    rd_chk(8'h08, 32'h3ff, 32'd822);
    rd_chk(8'h04, 32'h80, 32'h80);
    ctl_u.issue(4'h0, 11'h000);
    check(selected, 1'b0);
    ctl_u.issue(4'h8, 11'd100);
    rd_chk(8'h08, 32'h3ff, 32'd822);
    ctl_u.issue(4'h4, 11'h000);
    check(ctl_u.lastBus, 11'h008);
    ctl_u.issue(4'ha, 11'h003);
    ctl_u.issue(4'he, 11'h001);
    rd_chk(8'h04, 32'h80, 32'h0);
    ctl_u.issue(4'h8, 11'd823);
    rd_chk(8'h08, 32'h3ff, 32'd822);
    rd_chk(8'h04, 32'h84, 32'h84);
    ctl_u.issue(4'he, 11'h001);
    ctl_u.issue(4'hb, 11'h000);
    wait_idle();
    rd_chk(8'h08, 32'h7fe3ff, 32'h0);
    rd_chk(8'h04, 32'h80, 32'h80);
    $display("test seek done");
    ctl_u.issue(4'hd, 11'h0bf);
    wait_idle();
    rd_chk(8'h0c, 32'h7f, 32'h7f);
    $display("test offset done");
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b1, 8'h18, 32'hf);
    irq_chk(1'b0);
    ctl_u.issue(4'h7, 11'h000);
    ctl_u.issue(4'hf, 11'h000);
    rd_chk(8'h10, 32'h1, 32'h0);
    ctl_u.issue(4'h3, 11'h000);
    irq_chk(1'b1);
    apb(1'b1, 8'h14, 32'h0);
    irq_chk(1'b0);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b1, 8'h18, 32'h1);
    irq_chk(1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, errSeen}, 32'h1);
    check(rdData, 32'h0);
    $display("test interrupt done");
    ctl_u.issue(4'h5, 11'h000);
    check(selected, 1'b0);
    ctl_u.issue(4'ha, 11'h003);
    check(selected, 1'b1);
    apb(1'b1, 8'h00, 32'h310);
    apb(1'b1, 8'h00, 32'h311);
    @(posedge clk);
    check(selected, 1'b0);
    $display("test deselect done");
    stop_test();
  end

  initial
  begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule // disc_tag_bus_command_unit_tb
